// ---- logic/rcg_gate.sv ----
// run-mode clock gate register, group one, with apb slave, fault check and interrupt
`timescale 1ns/1ns
module rcg_gate
  import rcg_pkg::*;
(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // power mode requests, same clock domain
  input  wire logic            sleep_req,
  input  wire logic            deep_sleep_req,
  // peripheral access check
  input  wire rcg_periph_req_t periph_req,
  output logic                 periph_fault,
  // gated clock enables and interrupt
  output logic      [31:0]     periph_clk_en,
  output logic                 irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] run_q;
  logic [31:0] sleep_q;
  logic [31:0] deep_q;
  logic        auto_q;
  logic [1:0]  stat_q;
  logic [1:0]  irq_en_q;
  logic [5:0]  finfo_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        fault_q;
  logic [31:0] clk_en_q;
  logic        irq_q;
  logic [31:0] gate_d;
  logic [31:0] rdata_d;
  logic        hit_d;
  logic        wr_en;
  logic        fault_d;
  logic [1:0]  stat_set;
  logic [1:0]  stat_clr;
  rcg_mode_t   mode_d;

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign periph_fault  = fault_q;
  assign periph_clk_en = clk_en_q;
  assign irq           = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  // write lands only at the access edge, when pready is already high
  assign wr_en = psel && penable && pwrite && pready_q && !pslverr_q;

  // read mux and address hit; unmapped addresses answer with pslverr
  always_comb begin
    rdata_d = 32'h00000000;
    hit_d   = 1'b1;
    unique case (paddr)
      RCG_RUN_OFF:   rdata_d = run_q & RCG_GATE_MASK;
      RCG_SLEEP_OFF: rdata_d = sleep_q & RCG_GATE_MASK;
      RCG_DEEP_OFF:  rdata_d = deep_q & RCG_GATE_MASK;
      RCG_CFG_OFF:   rdata_d[RCG_CFG_AUTO_BIT] = auto_q;
      RCG_STAT_OFF:  rdata_d[1:0] = stat_q;
      RCG_CLR_OFF:   rdata_d = 32'h00000000; // write-only
      RCG_EN_OFF:    rdata_d[1:0] = irq_en_q;
      RCG_FINFO_OFF: rdata_d[5:0] = finfo_q;
      default:       hit_d = 1'b0;
    endcase
  end

  // one setup cycle, then a single access cycle with pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !hit_d;
      if (psel && !penable && !pwrite) begin
        prdata_q <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate registers
  // gates reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q   <= RCG_GATE_RESET;
      sleep_q <= RCG_GATE_RESET;
      deep_q  <= RCG_GATE_RESET;
      auto_q  <= 1'b0;
    end else if (wr_en) begin
      if (paddr == RCG_RUN_OFF) begin
        run_q <= pwdata & RCG_GATE_MASK;
      end
      if (paddr == RCG_SLEEP_OFF) begin
        sleep_q <= pwdata & RCG_GATE_MASK;
      end
      if (paddr == RCG_DEEP_OFF) begin
        deep_q <= pwdata & RCG_GATE_MASK;
      end
      if (paddr == RCG_CFG_OFF) begin
        auto_q <= pwdata[RCG_CFG_AUTO_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active gate set
  // low-power sets only with auto gating
  always_comb begin
    if (auto_q && deep_sleep_req) begin
      mode_d = RCG_MODE_DEEP;
    end else if (auto_q && sleep_req) begin
      mode_d = RCG_MODE_SLEEP;
    end else begin
      mode_d = RCG_MODE_RUN;
    end
  end

  always_comb begin
    unique case (mode_d)
      RCG_MODE_RUN:   gate_d = run_q;
      RCG_MODE_SLEEP: gate_d = sleep_q;
      RCG_MODE_DEEP:  gate_d = deep_q;
      default:        gate_d = run_q; // code 2'b11 never produced
    endcase
  end

  // enables only move on an edge
  // the downstream latch-based clock gate needs a clean flop-driven enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_q <= RCG_GATE_RESET;
    end else begin
      clk_en_q <= gate_d & RCG_GATE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access fault check
  // unclocked unit faults; reserved slots have no unit and fault too
  assign fault_d = periph_req.valid && !clk_en_q[periph_req.unit];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
      finfo_q <= 6'h00;
    end else begin
      fault_q <= fault_d;
      if (fault_d) begin
        finfo_q <= {periph_req.write, periph_req.unit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable
  assign stat_set[RCG_IRQ_RDFLT_BIT] = fault_d && !periph_req.write;
  assign stat_set[RCG_IRQ_WRFLT_BIT] = fault_d && periph_req.write;
  assign stat_clr = (wr_en && paddr == RCG_CLR_OFF) ? pwdata[1:0] : 2'h0;

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q   <= 2'h0;
      irq_en_q <= 2'h0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      if (wr_en && paddr == RCG_EN_OFF) begin
        irq_en_q <= pwdata[1:0] & RCG_IRQ_MASK;
      end
    end
  end

  // level interrupt, registered from the next status value, so it moves on the same edge as status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((stat_q & ~stat_clr | stat_set) & irq_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  logic seen_q;

  // marks the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  sequence s_run_write;
    wr_en && paddr == RCG_RUN_OFF;
  endsequence

  sequence s_running;
    !auto_q || (!sleep_req && !deep_sleep_req);
  endsequence

  property p_gate_follows_run;
    @(posedge pclk) disable iff (!presetn)
      (s_run_write ##1 s_running) |=> clk_en_q == ($past(pwdata, 2) & RCG_GATE_MASK);
  endproperty
  a_gate_follows_run: assert property (p_gate_follows_run)
    else $error("clock enable does not follow run gate write");

  property p_fault_on_gated;
    @(posedge pclk) disable iff (!presetn)
      (periph_req.valid && !clk_en_q[periph_req.unit]) |=> periph_fault && $past(periph_req.unit) == finfo_q[4:0];
  endproperty
  a_fault_on_gated: assert property (p_fault_on_gated)
    else $error("access to gated unit without fault");

  property p_reset_zero;
    @(posedge pclk) disable iff (!presetn)
      !seen_q |-> run_q == 32'h0 && clk_en_q == 32'h0 && sleep_q == 32'h0 && deep_q == 32'h0;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("gate not zero after reset");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      (pready_q && !pwrite && (paddr == RCG_RUN_OFF || paddr == RCG_SLEEP_OFF)) |-> (prdata_q & ~RCG_GATE_MASK) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved gate bit read nonzero");

  property p_comp_bits;
    @(posedge pclk) disable iff (!presetn)
      s_run_write |=> run_q[RCG_COMPARATOR_TWO_GATE_BIT:RCG_COMPARATOR_ZERO_GATE_BIT] == $past(pwdata[RCG_COMPARATOR_TWO_GATE_BIT:RCG_COMPARATOR_ZERO_GATE_BIT]);
  endproperty
  a_comp_bits: assert property (p_comp_bits)
    else $error("comparator gate bits not stored");

  property p_timer_bits;
    @(posedge pclk) disable iff (!presetn)
      s_run_write |=> run_q[RCG_TMR3_BIT:RCG_TMR0_BIT] == $past(pwdata[RCG_TMR3_BIT:RCG_TMR0_BIT]);
  endproperty
  a_timer_bits: assert property (p_timer_bits)
    else $error("timer gate bits not stored");

  property p_twi_bit;
    @(posedge pclk) disable iff (!presetn)
      s_run_write |=> run_q[RCG_TWI0_BIT] == $past(pwdata[RCG_TWI0_BIT]);
  endproperty
  a_twi_bit: assert property (p_twi_bit)
    else $error("two-wire gate bit not stored");

  property p_qdec_bit;
    @(posedge pclk) disable iff (!presetn)
      s_run_write |=> run_q[RCG_QDEC_BIT] == $past(pwdata[RCG_QDEC_BIT]);
  endproperty
  a_qdec_bit: assert property (p_qdec_bit)
    else $error("quadrature gate bit not stored");

  property p_ssp_bits;
    @(posedge pclk) disable iff (!presetn)
      s_run_write |=> run_q[RCG_SSP1_BIT:RCG_SSP0_BIT] == $past(pwdata[RCG_SSP1_BIT:RCG_SSP0_BIT]);
  endproperty
  a_ssp_bits: assert property (p_ssp_bits)
    else $error("sync serial gate bits not stored");

  property p_asp_bits;
    @(posedge pclk) disable iff (!presetn)
      s_run_write |=> run_q[RCG_ASP2_BIT:RCG_ASP0_BIT] == $past(pwdata[RCG_ASP2_BIT:RCG_ASP0_BIT]) && !run_q[3];
  endproperty
  a_asp_bits: assert property (p_asp_bits)
    else $error("async serial gate bits wrong");

  property p_sleep_set;
    @(posedge pclk) disable iff (!presetn)
      (auto_q && sleep_req && !deep_sleep_req) |=> clk_en_q == $past(sleep_q);
  endproperty
  a_sleep_set: assert property (p_sleep_set)
    else $error("sleep gate set not applied");

  property p_auto_off;
    @(posedge pclk) disable iff (!presetn)
      (!auto_q && (sleep_req || deep_sleep_req)) |=> clk_en_q == $past(run_q);
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("low-power set applied without auto gating");

  property p_enable_stable;
    @(posedge pclk) disable iff (!presetn)
      (seen_q && $stable(gate_d) && $stable(clk_en_q)) |=> $stable(clk_en_q);
  endproperty
  a_enable_stable: assert property (p_enable_stable)
    else $error("clock enable moved without cause");

endmodule : rcg_gate

// ---- pkg/rcg_pkg.sv ----
// package of constants and types for the run-mode clock gate register block, group one
package rcg_pkg;

  // register byte offsets
  localparam logic [11:0] RCG_RUN_OFF   = 12'h104;
  localparam logic [11:0] RCG_SLEEP_OFF = 12'h114;
  localparam logic [11:0] RCG_DEEP_OFF  = 12'h124;
  localparam logic [11:0] RCG_CFG_OFF   = 12'h160;
  localparam logic [11:0] RCG_STAT_OFF  = 12'h200;
  localparam logic [11:0] RCG_CLR_OFF   = 12'h204;
  localparam logic [11:0] RCG_EN_OFF    = 12'h208;
  localparam logic [11:0] RCG_FINFO_OFF = 12'h20c;

  // implemented gate bits, reserved ones are zero
  localparam logic [31:0] RCG_GATE_MASK  = 32'h070f1137;
  localparam logic [31:0] RCG_GATE_RESET = 32'h00000000;

  // gate bit positions
  localparam int RCG_COMPARATOR_TWO_GATE_BIT = 26;
  localparam int RCG_COMPARATOR_ZERO_GATE_BIT = 24;
  localparam int RCG_TMR3_BIT  = 19;
  localparam int RCG_TMR0_BIT  = 16;
  localparam int RCG_TWI0_BIT  = 12;
  localparam int RCG_QDEC_BIT  = 8;
  localparam int RCG_SSP1_BIT  = 5;
  localparam int RCG_SSP0_BIT  = 4;
  localparam int RCG_ASP2_BIT  = 2;
  localparam int RCG_ASP0_BIT  = 0;

  // configuration and interrupt fields
  localparam int          RCG_CFG_AUTO_BIT  = 0;
  localparam logic [1:0]  RCG_IRQ_MASK      = 2'h3;
  localparam int          RCG_IRQ_RDFLT_BIT = 0;
  localparam int          RCG_IRQ_WRFLT_BIT = 1;

  // access request from the peripheral bus decoder
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [4:0] unit;
  } rcg_periph_req_t;

  // power mode that picks the active gate set
  typedef enum logic [1:0] {
    RCG_MODE_RUN   = 2'b00,
    RCG_MODE_SLEEP = 2'b01,
    RCG_MODE_DEEP  = 2'b10
  } rcg_mode_t;

endpackage : rcg_pkg

// ---- testbench/rcg_gate_tb_top.sv ----
// self-checking bench for the run-mode clock gate register block
`timescale 1ns/1ns
module rcg_gate_tb_top
  import rcg_pkg::*;
;
  localparam logic [31:0] RW_BITS = 32'h070f1137;
  logic            pclk, presetn, psel, penable, pwrite, sleep_req, deep_sleep_req;
  logic            pready, pslverr, periph_fault, irq, req_d;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, periph_clk_en, gate, sl, dp;
  rcg_periph_req_t periph_req;
  int              fails, n_compared, cyc;
  logic [33:0]     apb_q[$];
  logic            fault_q[$];

  rcg_gate rcg_gate_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .periph_req(periph_req), .periph_fault(periph_fault), .periph_clk_en(periph_clk_en), .irq(irq));
  rcg_periph_model rcg_periph_model_i (.pclk(pclk), .periph_req(periph_req));

  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // apb master: note the expected answer, hold the request until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err,
                     input logic [31:0] exp);
    @(posedge pclk);
    apb_q.push_back({~wr, err, exp});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic acc(input logic wr, input logic [4:0] u, input logic exp);
    fault_q.push_back(exp);
    rcg_periph_model_i.access(wr, u);
  endtask : acc

  // write the run register, read it back, then probe one unit
  task automatic wr_run(input logic [31:0] d, input logic [4:0] u);
    gate = d & RW_BITS;
    apb(1'b1, RCG_RUN_OFF, d, 1'b0, 32'h0);
    apb(1'b0, RCG_RUN_OFF, 32'h0, 1'b0, gate);
    chk(periph_clk_en, gate);
    acc(u[0], u, ~gate[u]);
  endtask : wr_run

  ////////////////////////////////////////////////////////////////////////
  // monitor: oldest note is compared whenever an answer appears
  always @(posedge pclk) begin
    req_d <= periph_req.valid;
    if (psel && penable && pready === 1'b1) begin
      chk({31'h0, pslverr}, {31'h0, apb_q[0][32]});
      if (apb_q[0][33]) chk(prdata, apb_q[0][31:0]);
      void'(apb_q.pop_front());
    end
    if (req_d) chk({31'h0, periph_fault}, {31'h0, fault_q.pop_front()});
  end

  // hang guard, ceiling well above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 8000) begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, sleep_req, deep_sleep_req} = '0;
    paddr = '0;
    pwdata = '0;
    {fails, n_compared} = '0;
    void'($urandom(51800));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RCG_RUN_OFF, 32'h0, 1'b0, 32'h0);
    apb(1'b0, RCG_SLEEP_OFF, 32'h0, 1'b0, 32'h0);
    apb(1'b0, RCG_DEEP_OFF, 32'h0, 1'b0, 32'h0);
    chk(periph_clk_en, 32'h0);
    // walk every bit, reserved ones must stay zero
    for (int b = 0; b < 32; b++) wr_run(32'h1 << b, b[4:0]);
    // unmapped place is refused and leaves the gates alone
    apb(1'b1, 12'h0f0, 32'hffffffff, 1'b1, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0, 1'b1, 32'h0);
    apb(1'b0, RCG_RUN_OFF, 32'h0, 1'b0, gate);
    chk(periph_clk_en, gate);
    repeat (8) wr_run($urandom, 5'($urandom_range(31, 0)));
    // companion sets only while auto gating is selected
    sl = $urandom;
    dp = $urandom;
    apb(1'b1, RCG_SLEEP_OFF, sl, 1'b0, 32'h0);
    apb(1'b1, RCG_DEEP_OFF, dp, 1'b0, 32'h0);
    apb(1'b0, RCG_SLEEP_OFF, 32'h0, 1'b0, sl & RW_BITS);
    apb(1'b0, RCG_DEEP_OFF, 32'h0, 1'b0, dp & RW_BITS);
    sleep_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(periph_clk_en, gate);
    apb(1'b1, RCG_CFG_OFF, 32'h1, 1'b0, 32'h0);
    // mode moves at the access edge, the enables one edge later
    repeat (2) @(posedge pclk);
    chk(periph_clk_en, sl & RW_BITS);
    deep_sleep_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(periph_clk_en, dp & RW_BITS);
    sleep_req <= 1'b0;
    deep_sleep_req <= 1'b0;
    apb(1'b1, RCG_CFG_OFF, 32'h0, 1'b0, 32'h0);
    chk(periph_clk_en, gate);
    // fault events feed the interrupt: raise, clear, mask
    wr_run(32'h0, 5'd4);
    apb(1'b1, RCG_CLR_OFF, 32'h3, 1'b0, 32'h0);
    apb(1'b1, RCG_EN_OFF, 32'h3, 1'b0, 32'h0);
    acc(1'b0, 5'd3, 1'b1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, RCG_STAT_OFF, 32'h0, 1'b0, 32'h1);
    apb(1'b1, RCG_CLR_OFF, 32'h1, 1'b0, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, RCG_EN_OFF, 32'h0, 1'b0, 32'h0);
    acc(1'b1, 5'd13, 1'b1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, RCG_STAT_OFF, 32'h0, 1'b0, 32'h2);
    apb(1'b0, RCG_FINFO_OFF, 32'h0, 1'b0, 32'h0000002d);
    // a reset in mid-run clears the gates again
    wr_run(32'hffffffff, 5'd0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RCG_RUN_OFF, 32'h0, 1'b0, 32'h0);
    chk(periph_clk_en, 32'h0);
    // let the monitor take the last answers before the verdict
    repeat (2) @(posedge pclk);
    tally_and_finish();
  end
endmodule : rcg_gate_tb_top

// ---- testbench/rcg_periph_model.sv ----
// partner model: peripheral bus decoder issuing unit access requests
`timescale 1ns/1ns
module rcg_periph_model
  import rcg_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // access request toward the gate block
  output rcg_periph_req_t periph_req
);
  initial periph_req = '0;
  // one-cycle pulse; fields scrambled once released so stale values never match
  task automatic access(input logic wr, input logic [4:0] u);
    @(posedge pclk);
    periph_req <= '{1'b1, wr, u};
    @(posedge pclk);
    periph_req <= '{1'b0, ~wr, ~u};
  endtask : access
endmodule : rcg_periph_model
